/* pkg/smc_pkg.sv */
// Constants and types of the supply monitor control block.
// Assumes a 125 MHz system clock and word-aligned AHB-Lite access.
package smc_pkg;

	// Register indices; byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [3:0] IDX_MODE = 4'h0;
	localparam logic [3:0] IDX_THRESH = 4'h1;
	localparam logic [3:0] IDX_WLEVEL = 4'h8;
	localparam logic [3:0] IDX_ICTRL = 4'h9;
	localparam logic [3:0] IDX_IFLAG = 4'hA;
	localparam logic [3:0] IDX_STATUS = 4'hB;

	// Field positions
	localparam int MODE_LP_LSB = 0;
	localparam int MODE_RUN_LSB = 2;
	localparam int MODE_RATE_BIT = 4;
	localparam int ICTRL_IE_BIT = 0;
	localparam int ICTRL_CFG_LSB = 1;
	localparam int IFLAG_BIT = 0;

	// Reset values of software fields
	localparam logic [1:0] WLEVEL_RST = 2'h0;
	localparam logic [1:0] CFG_RST = 2'h0;

	// Operating modes of the monitor
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_ON = 2'b01,
		MODE_SAMPLED = 2'b10,
		MODE_ON_HOLD = 2'b11
	} smc_mode_t;

	// Crossing selections
	localparam logic [1:0] CROSS_DOWN = 2'h0;
	localparam logic [1:0] CROSS_UP = 2'h1;
	localparam logic [1:0] CROSS_ANY = 2'h2;

	// Comparator power sequencer states
	typedef enum logic [1:0] {
		SMP_OFF = 2'b00,
		SMP_CONT = 2'b01,
		SMP_WAIT = 2'b10,
		SMP_ON = 2'b11
	} smc_smp_t;

	// Settings loaded from the configuration fuse
	typedef struct packed {
		logic sample_rate_select;
		logic [1:0] run_mode;
		logic [1:0] lp_mode;
		logic [2:0] threshold_select;
	} smc_fuse_t;

	// Timing
	localparam longint CLK_PERIOD_PS = 8000;
	localparam longint RATE_FAST_HZ = 1000;
	localparam longint RATE_SLOW_HZ = 125;
	localparam longint SAMPLE_ON_NS = 1000;
	localparam longint PS_PER_S = 64'd1000000000000;
	localparam int CYC_FAST = int'(PS_PER_S / (RATE_FAST_HZ * CLK_PERIOD_PS));
	localparam int CYC_SLOW = int'(PS_PER_S / (RATE_SLOW_HZ * CLK_PERIOD_PS));
	localparam int CYC_ON =
		int'((SAMPLE_ON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [2:0] KEY_WINDOW_INSTR = 3'h4;

endpackage : smc_pkg

/* design/smc_top.sv */
// Supply monitor control: fuse-loaded modes, sleep switching, protected
// low-power mode, early-warning crossing flag and request, AHB-Lite regs.
// Assumes analog comparators outside and fuses stable at reset release.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module smc_top
	import smc_pkg::*;
#(
	parameter int PERIOD_FAST_CYC = CYC_FAST,
	parameter int PERIOD_SLOW_CYC = CYC_SLOW,
	parameter int ON_CYC = CYC_ON
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Fuses and CPU status
	input wire smc_fuse_t FUSE_CFG,
	input wire logic KEY_UNLOCK,
	input wire logic INSTR_RETIRE,
	input wire logic CPU_HALTED,
	input wire logic SLEEPING,
	// Analog comparators
	input wire logic BOD_BELOW,
	input wire logic WARN_BELOW,
	input wire logic MON_READY,
	output logic MON_POWER,
	output logic [2:0] THRESHOLD_SELECT,
	output logic [1:0] WARNING_LEVEL_SELECT,
	// System outputs
	output logic BROWNOUT_RESET,
	output logic WAKE_HOLD,
	output logic IRQ
);

	// Decode a byte address to {hit, index}; unmapped gives hit low
	function automatic logic [4:0] addr_idx(input logic [ADDR_W-1:0] a);
		logic [3:0] i;
		logic ok;
		i = a[5:2];
		ok = (a[ADDR_W-1:6] == '0) && (a[1:0] == 2'b00) &&
			(i == IDX_MODE || i == IDX_THRESH || i == IDX_WLEVEL ||
			i == IDX_ICTRL || i == IDX_IFLAG || i == IDX_STATUS);
		return {ok, i};
	endfunction : addr_idx

	// Configuration state
	logic loaded;
	logic rate_sel;
	logic [1:0] run_mode;
	logic [1:0] lp_mode;
	logic [2:0] thresh;
	logic [1:0] wlevel;
	logic ie;
	logic [1:0] cfg;
	logic [2:0] key_cnt;
	logic next_loaded;
	logic next_rate_sel;
	logic [1:0] next_run_mode;
	logic [1:0] next_lp_mode;
	logic [2:0] next_thresh;
	logic [1:0] next_wlevel;
	logic next_ie;
	logic [1:0] next_cfg;
	logic [2:0] next_key_cnt;

	// Bus state
	logic wr_pend;
	logic [3:0] wr_idx;
	logic [31:0] rdata;
	logic next_wr_pend;
	logic [3:0] next_wr_idx;
	logic [31:0] next_rdata;
	logic rdy;
	logic [4:0] dec;
	logic accept;

	// Monitor state
	smc_smp_t smp;
	smc_smp_t next_smp;
	logic [19:0] cnt;
	logic [19:0] next_cnt;
	logic flag;
	logic warn_state;
	logic state_valid;
	logic bor;
	logic irq;
	logic hold;
	logic next_flag;
	logic next_warn_state;
	logic next_state_valid;
	logic next_bor;
	logic next_irq;
	logic next_hold;

	// Shared decode
	smc_mode_t eff;
	logic active;
	logic warn_on;
	logic sample_now;
	logic wr_mode;
	logic wr_flag;
	logic hit;
	logic now_above;
	logic [19:0] period_last;

	localparam logic [19:0] FAST_LAST = 20'(PERIOD_FAST_CYC - 1);
	localparam logic [19:0] SLOW_LAST = 20'(PERIOD_SLOW_CYC - 1);
	localparam logic [19:0] ON_LAST = 20'(ON_CYC - 1);

	// Low-power field code 3 is reserved; treat it as off
	always_comb begin
		if (SLEEPING) begin
			eff = (lp_mode == 2'h3) ? MODE_OFF : smc_mode_t'(lp_mode);
		end else begin
			eff = smc_mode_t'(run_mode);
		end
	end

	assign active = loaded && (eff != MODE_OFF);
	assign warn_on = active && ie;
	assign period_last = rate_sel ? SLOW_LAST : FAST_LAST;
	// Comparator result is trusted every cycle in continuous mode, else only at the end of a power pulse
	assign sample_now = (smp == SMP_CONT) ||
		((smp == SMP_ON) && (cnt == ON_LAST));
	assign now_above = ~WARN_BELOW;
	assign wr_mode = wr_pend && (wr_idx == IDX_MODE);
	assign wr_flag = wr_pend && (wr_idx == IDX_IFLAG) &&
		HWDATA[IFLAG_BIT];
	assign dec = addr_idx(HADDR);
	assign accept = HSEL && HREADY && HTRANS[1];

	// Crossing detector; first sample after enable counts as any-crossing
	always_comb begin
		hit = 1'b0;
		if (warn_on && sample_now) begin
			if (!state_valid) begin
				hit = (cfg == CROSS_ANY);
			end else begin
				case (cfg)
					CROSS_DOWN: hit = warn_state && !now_above;
					CROSS_UP: hit = !warn_state && now_above;
					CROSS_ANY: hit = warn_state != now_above;
					default: hit = 1'b0;
				endcase
			end
		end
	end

	// Bus: zero wait states, read data captured in the address phase
	always_comb begin
		next_wr_pend = accept && HWRITE && dec[4];
		next_wr_idx = dec[3:0];
		next_rdata = rdata;
		if (accept && !HWRITE) begin
			next_rdata = 32'h0000_0000;
			if (dec[4]) begin
				case (dec[3:0])
					IDX_MODE: next_rdata[4:0] =
						{rate_sel, run_mode, lp_mode};
					IDX_THRESH: next_rdata[2:0] = thresh;
					IDX_WLEVEL: next_rdata[1:0] = wlevel;
					IDX_ICTRL: next_rdata[2:0] = {cfg, ie};
					IDX_IFLAG: next_rdata[IFLAG_BIT] = flag;
					IDX_STATUS: next_rdata[0] = warn_state;
					default: next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend <= 1'b0;
			wr_idx <= 4'h0;
			rdata <= 32'h0000_0000;
			rdy <= 1'b0;
		end else begin
			// Ready from a flop: low in reset, high from the first edge on
			rdy <= 1'b1;
			wr_pend <= next_wr_pend;
			wr_idx <= next_wr_idx;
			rdata <= next_rdata;
		end
	end

	// Configuration: fuse load once after reset release, then writes
	always_comb begin
		next_loaded = 1'b1;
		next_rate_sel = rate_sel;
		next_run_mode = run_mode;
		next_lp_mode = lp_mode;
		next_thresh = thresh;
		next_wlevel = wlevel;
		next_ie = ie;
		next_cfg = cfg;
		next_key_cnt = key_cnt;
		if (INSTR_RETIRE && key_cnt != 3'h0) begin
			next_key_cnt = key_cnt - 3'h1;
		end
		if (!loaded) begin
			next_rate_sel = FUSE_CFG.sample_rate_select;
			next_run_mode = FUSE_CFG.run_mode;
			next_lp_mode = FUSE_CFG.lp_mode;
			next_thresh = FUSE_CFG.threshold_select;
		end else if (wr_mode) begin
			// Run mode, rate and threshold ignore writes
			if (key_cnt != 3'h0) begin
				next_lp_mode = HWDATA[MODE_LP_LSB +: 2];
			end
			next_key_cnt = 3'h0;
		end
		if (wr_pend && wr_idx == IDX_WLEVEL) begin
			next_wlevel = HWDATA[1:0];
		end
		if (wr_pend && wr_idx == IDX_ICTRL) begin
			next_ie = HWDATA[ICTRL_IE_BIT];
			next_cfg = HWDATA[ICTRL_CFG_LSB +: 2];
		end
		if (KEY_UNLOCK) begin
			next_key_cnt = KEY_WINDOW_INSTR;
		end
	end

	// Fuse copies reset to constants; the load happens on the first edge
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			loaded <= 1'b0;
			rate_sel <= 1'b0;
			run_mode <= 2'h0;
			lp_mode <= 2'h0;
			thresh <= 3'h0;
			wlevel <= WLEVEL_RST;
			ie <= 1'b0;
			cfg <= CFG_RST;
			key_cnt <= 3'h0;
		end else begin
			loaded <= next_loaded;
			rate_sel <= next_rate_sel;
			run_mode <= next_run_mode;
			lp_mode <= next_lp_mode;
			thresh <= next_thresh;
			wlevel <= next_wlevel;
			ie <= next_ie;
			cfg <= next_cfg;
			key_cnt <= next_key_cnt;
		end
	end

	// Comparator power sequencer
	always_comb begin
		next_smp = smp;
		next_cnt = cnt + 20'h1;
		case (smp)
			SMP_OFF: begin
				next_cnt = 20'h0;
				if (active) begin
					next_smp = (eff == MODE_SAMPLED) ? SMP_WAIT : SMP_CONT;
				end
			end
			SMP_CONT: begin
				next_cnt = 20'h0;
				if (eff == MODE_SAMPLED) begin
					next_smp = SMP_WAIT;
				end
			end
			SMP_WAIT: begin
				if (eff != MODE_SAMPLED) begin
					next_smp = SMP_CONT;
				end else if (cnt >= period_last) begin
					next_smp = SMP_ON;
					next_cnt = 20'h0;
				end
			end
			SMP_ON: begin
				if (cnt == ON_LAST) begin
					next_smp = SMP_WAIT;
					next_cnt = 20'h0;
				end
			end
			default: begin
				next_smp = SMP_OFF;
				next_cnt = 20'h0;
			end
		endcase
		if (!active) begin
			next_smp = SMP_OFF;
			next_cnt = 20'h0;
		end
	end

	// Flag, warning state, reset and request
	always_comb begin
		// Set wins over a same-cycle software clear
		next_flag = hit || (flag && !wr_flag);
		next_warn_state = warn_state;
		next_state_valid = state_valid && warn_on;
		if (warn_on && sample_now) begin
			next_warn_state = now_above;
			next_state_valid = 1'b1;
		end
		next_bor = bor;
		if (!active) begin
			next_bor = 1'b0;
		end else if (sample_now) begin
			next_bor = BOD_BELOW;
		end
		next_irq = ie && next_flag && !CPU_HALTED;
		next_hold = loaded && !SLEEPING &&
			(run_mode == MODE_ON_HOLD) && !MON_READY;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			smp <= SMP_OFF;
			cnt <= 20'h0;
			flag <= 1'b0;
			warn_state <= 1'b0;
			state_valid <= 1'b0;
			bor <= 1'b0;
			irq <= 1'b0;
			hold <= 1'b0;
		end else begin
			smp <= next_smp;
			cnt <= next_cnt;
			flag <= next_flag;
			warn_state <= next_warn_state;
			state_valid <= next_state_valid;
			bor <= next_bor;
			irq <= next_irq;
			hold <= next_hold;
		end
	end

	// Output flops; power line is registered from the next state
	logic mon_power;
	logic [2:0] thr_out;
	logic [1:0] wl_out;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mon_power <= 1'b0;
			thr_out <= 3'h0;
			wl_out <= 2'h0;
		end else begin
			mon_power <= (next_smp == SMP_CONT) || (next_smp == SMP_ON);
			thr_out <= next_thresh;
			wl_out <= next_wlevel;
		end
	end

	assign HRDATA = rdata;
	assign HREADYOUT = rdy;
	assign HRESP = 1'b0;
	assign MON_POWER = mon_power;
	assign THRESHOLD_SELECT = thr_out;
	assign WARNING_LEVEL_SELECT = wl_out;
	assign BROWNOUT_RESET = bor;
	assign WAKE_HOLD = hold;
	assign IRQ = irq;

	// Checks
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	fuse_load_a: assert property ($rose(loaded) |->
		run_mode == $past(FUSE_CFG.run_mode) &&
		thresh == $past(FUSE_CFG.threshold_select))
		else $error("fuse settings not loaded");

	run_fixed_a: assert property (loaded && $past(loaded) |->
		$stable(run_mode) && $stable(thresh))
		else $error("fuse-loaded field changed");

	lp_guard_a: assert property (loaded && wr_mode && key_cnt == 3'h0
		|=> $stable(lp_mode))
		else $error("unkeyed write changed low-power mode");

	// Flag is the updated one, so a same-cycle clear drops the request too
	irq_gate_a: assert property (
		IRQ == ($past(ie) && flag && !$past(CPU_HALTED)))
		else $error("request does not match enable and flag");

	halt_quiet_a: assert property (CPU_HALTED |=> !IRQ)
		else $error("request raised while halted");

	flag_hold_a: assert property (!active |=> !$rose(flag))
		else $error("flag set while monitor disabled");

	w1c_a: assert property (wr_flag && !hit |=> !flag)
		else $error("write one did not clear flag");

	off_quiet_a: assert property (!active ##1 !active |-> !MON_POWER)
		else $error("comparator powered while off");

	bor_a: assert property (active && sample_now && BOD_BELOW
		|=> BROWNOUT_RESET)
		else $error("brown-out reset missing");

	sleep_mode_a: assert property (loaded && SLEEPING && lp_mode != 2'h3
		|-> eff == smc_mode_t'(lp_mode))
		else $error("sleep mode not applied");

	cov_sample_c: cover property (smp == SMP_WAIT ##1 smp == SMP_ON);
	cov_cross_c: cover property (hit ##1 IRQ);
	cov_unlock_c: cover property (KEY_UNLOCK ##[1:4] wr_mode);
	cov_sleep_c: cover property ($rose(SLEEPING) ##1 active);

endmodule : smc_top

`default_nettype wire

/* testbench/smc_cmp_model.sv */
// Behavioural supply comparators on the far side of the monitor block.
// Assumes the bench sets the supply condition and drives the fuse word.
`timescale 1ns/1ps
`default_nettype none

module smc_cmp_model (
	// Clock and supply condition
	input wire logic clk,
	input wire logic supply_low,
	input wire logic supply_warn,
	// Comparator side
	input wire logic mon_power,
	output logic bod_below,
	output logic warn_below,
	output logic mon_ready
);
	initial begin
		bod_below = 1'h0;
		warn_below = 1'h0;
		mon_ready = 1'h0;
	end

	// Unpowered bod_below and warn_below toggle, so a stale level never passes for a sample
	always @(posedge clk) begin
		mon_ready <= mon_power;
		if (mon_power) begin
			bod_below <= supply_low;
			warn_below <= supply_warn;
		end else begin
			bod_below <= ~bod_below;
			warn_below <= ~warn_below;
		end
	end
endmodule : smc_cmp_model

`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench: AHB-Lite register access, key window, crossings.
// Assumes zero-wait slave; short sampling counts set below.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import smc_pkg::*;
;
	localparam int PF = 20;
	localparam int PS = 40;
	localparam int PON = 4;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic hsel, hwrite, key, retire, halted, sleeping, sup_low, sup_warn;
	logic [ADDR_W-1:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic hreadyout, hresp, bod_below, warn_below, mon_ready, mon_power;
	logic brown, irq, wake_hold;
	logic [2:0] thr_sel;
	logic [1:0] wl_sel;
	smc_fuse_t fuse, f1, f2, f3;
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	int hi, per;

	// 125 MHz system clock
	always #4 clk = ~clk;

	smc_top #(.PERIOD_FAST_CYC(PF), .PERIOD_SLOW_CYC(PS), .ON_CYC(PON)) uut (
		.REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .FUSE_CFG(fuse), .KEY_UNLOCK(key),
		.INSTR_RETIRE(retire), .CPU_HALTED(halted), .SLEEPING(sleeping),
		.BOD_BELOW(bod_below), .WARN_BELOW(warn_below),
		.MON_READY(mon_ready), .MON_POWER(mon_power),
		.THRESHOLD_SELECT(thr_sel), .WARNING_LEVEL_SELECT(wl_sel),
		.BROWNOUT_RESET(brown), .WAKE_HOLD(wake_hold), .IRQ(irq));

	smc_cmp_model cmp (.clk(clk), .supply_low(sup_low),
		.supply_warn(sup_warn), .mon_power(mon_power),
		.bod_below(bod_below), .warn_below(warn_below),
		.mon_ready(mon_ready));

	task test_done();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// A hang shows up as a mismatch rather than a stuck run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			test_done();
		end
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// One single word transfer; waits on hready in both phases
	task ahb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {6'h00, idx, 2'h0};
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task wr(input logic [3:0] idx, input logic [31:0] wd);
		ahb(1'h1, idx, wd);
	endtask : wr

	task rdc(input string nm, input logic [3:0] idx, input logic [31:0] ex);
		ahb(1'h0, idx, 32'h0);
		chk(nm, rd, ex);
	endtask : rdc

	// Key pulse one cycle ahead of the protected write
	task keyed_wr(input logic [31:0] wd);
		key <= 1'h1;
		@(posedge clk);
		key <= 1'h0;
		wr(IDX_MODE, wd);
	endtask : keyed_wr

	task do_reset(input smc_fuse_t f);
		rst_n <= 1'h0;
		fuse <= f;
		cyc(2);
		rst_n <= 1'h1;
		cyc(2);
	endtask : do_reset

	// Skips any pulse in progress, then times one full power pulse
	task pulse(output int h, output int p);
		int n;
		n = 0;
		h = 0;
		p = 0;
		while (mon_power === 1'h1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		while (mon_power !== 1'h1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		while (mon_power === 1'h1 && p < 200) begin
			@(posedge clk);
			h++;
			p++;
		end
		while (mon_power !== 1'h1 && p < 200) begin
			@(posedge clk);
			p++;
		end
	endtask : pulse

	function automatic logic [31:0] mval(smc_fuse_t f, logic [1:0] lp);
		return (32'(f.sample_rate_select) << MODE_RATE_BIT) |
			(32'(f.run_mode) << MODE_RUN_LSB) | (32'(lp) << MODE_LP_LSB);
	endfunction : mval

	initial begin
		{hsel, hwrite, key, retire, halted, sleeping, sup_low, sup_warn} = '0;
		haddr = '0;
		htrans = 2'h0;
		hwdata = 32'h0;
		f1 = '{1'h0, 2'h1, 2'h2, 3'h5};
		f2 = '{1'h1, 2'h2, 2'h0, 3'h3};
		f3 = '{1'h0, 2'h3, 2'h0, 3'h1};
		fuse = f1;
		do_reset(f1);
		rdc("mode", IDX_MODE, mval(f1, f1.lp_mode));
		chk("thr_port", 32'(thr_sel), 32'(f1.threshold_select));
		wr(IDX_THRESH, 32'h0);
		rdc("thresh", IDX_THRESH, 32'(f1.threshold_select));
		wr(4'h4, 32'hFFFFFFFF);
		rdc("unmapped", 4'h4, 32'h0);
		wr(IDX_WLEVEL, 32'h2);
		rdc("wlevel", IDX_WLEVEL, 32'h2);
		chk("wl_port", 32'(wl_sel), 32'h2);
		// No sample taken yet while the warning function is off
		rdc("status", IDX_STATUS, 32'h0);
		// Every crossing code, both directions, continuous mode
		for (int c = 0; c < 3; c++) begin
			wr(IDX_ICTRL, (32'(c) << ICTRL_CFG_LSB) | 32'h1);
			cyc(6);
			rdc("flag_on", IDX_IFLAG, 32'(c == 2));
			wr(IDX_IFLAG, 32'h1);
			sup_warn <= 1'h1;
			cyc(6);
			chk("irq_dn", 32'(irq), 32'(c != 1));
			rdc("flag_dn", IDX_IFLAG, 32'(c != 1));
			wr(IDX_IFLAG, 32'h1);
			cyc(2);
			chk("irq_clr", 32'(irq), 32'h0);
			sup_warn <= 1'h0;
			cyc(6);
			rdc("flag_up", IDX_IFLAG, 32'(c != 0));
			wr(IDX_IFLAG, 32'h1);
			wr(IDX_ICTRL, 32'h0);
		end
		// Enable bit off, then request held back while halted
		wr(IDX_ICTRL, 32'h4);
		sup_warn <= 1'h1;
		cyc(6);
		rdc("flag_ie0", IDX_IFLAG, 32'h0);
		wr(IDX_ICTRL, 32'h3);
		halted <= 1'h1;
		sup_warn <= 1'h0;
		cyc(6);
		chk("irq_halt", 32'(irq), 32'h0);
		rdc("flag_halt", IDX_IFLAG, 32'h1);
		halted <= 1'h0;
		cyc(2);
		chk("irq_run", 32'(irq), 32'h1);
		wr(IDX_IFLAG, 32'h1);
		wr(IDX_ICTRL, 32'h0);
		// Protected low-power field
		keyed_wr(32'h0);
		rdc("lp_key", IDX_MODE, mval(f1, 2'h0));
		wr(IDX_MODE, 32'h1);
		rdc("lp_nokey", IDX_MODE, mval(f1, 2'h0));
		key <= 1'h1;
		@(posedge clk);
		key <= 1'h0;
		retire <= 1'h1;
		cyc(4);
		retire <= 1'h0;
		wr(IDX_MODE, 32'h1);
		rdc("lp_late", IDX_MODE, mval(f1, 2'h0));
		// Sleep with the low-power mode off, then wake
		sleeping <= 1'h1;
		sup_low <= 1'h1;
		cyc(6);
		chk("pwr_sleep", 32'(mon_power), 32'h0);
		chk("bor_sleep", 32'(brown), 32'h0);
		sleeping <= 1'h0;
		cyc(6);
		chk("pwr_wake", 32'(mon_power), 32'h1);
		chk("bor_wake", 32'(brown), 32'h1);
		sup_low <= 1'h0;
		cyc(6);
		chk("bor_clr", 32'(brown), 32'h0);
		// Sampled sleep mode at the fast rate
		keyed_wr(32'h2);
		sleeping <= 1'h1;
		pulse(hi, per);
		chk("on_fast", 32'(hi), 32'(PON));
		chk("per_fast", 32'(per), 32'(PF + PON));
		sleeping <= 1'h0;
		// Second reset: sampled run mode at the slow rate
		do_reset(f2);
		rdc("mode2", IDX_MODE, mval(f2, f2.lp_mode));
		pulse(hi, per);
		chk("on_slow", 32'(hi), 32'(PON));
		chk("per_slow", 32'(per), 32'(PS + PON));
		// Third reset: run code 3 holds wake-up until the comparator is ready
		do_reset(f3);
		sleeping <= 1'h1;
		cyc(6);
		chk("hold_sleep", 32'(wake_hold), 32'h0);
		sleeping <= 1'h0;
		cyc(2);
		chk("hold_wake", 32'(wake_hold), 32'h1);
		cyc(6);
		chk("hold_ready", 32'(wake_hold), 32'h0);
		test_done();
	end
endmodule : testbench

`default_nettype wire
